/* hdl/sdfb_consts.svh */
`ifndef SDFB_CONSTS_SVH
`define SDFB_CONSTS_SVH

// address space decode
`define SDFB_SDRAM_SPACE      2'h1
`define SDFB_ADDR_TOP_HI      31
`define SDFB_ADDR_TOP_LO      30
`define SDFB_BANK_SEL_HI      29
`define SDFB_BANK_SEL_LO      28
// reserved window inside sdram space: bits 27:26 all ones
`define SDFB_RSVD_HI          27
`define SDFB_RSVD_LO          26
`define SDFB_RSVD_CODE        2'h3
`define SDFB_ROW_HI           25
`define SDFB_ROW_LO           12
`define SDFB_COL_HI           11
`define SDFB_COL_LO           2
`define SDFB_A10_BIT          10

// timing in ns at 40 MHz
`define SDFB_CLK_NS           25
`define SDFB_TRCD_NS          50
`define SDFB_TRCD_CYC         ((`SDFB_TRCD_NS + `SDFB_CLK_NS - 1) / `SDFB_CLK_NS)
`define SDFB_TRP_NS           50
`define SDFB_TRP_CYC          ((`SDFB_TRP_NS + `SDFB_CLK_NS - 1) / `SDFB_CLK_NS)

// reset values of pin registers
`define SDFB_CMD_RST          3'h7
`define SDFB_BANK_RST         4'h0

`endif

/* hdl/sdfb_ctrl.sv */
`timescale 1ns/100ps
`include "sdfb_consts.svh"
// ==========================================================
// Notes on behaviour
// - serve asserted dma request per channel setup
// - ignore requests on uninitialised channels
// - io write strobe throughout fly-by read data
// - io read strobe in fly-by write data
// - io output enable only on fly-by
// - exactly one bank select per command
// - only bus owner drives bank selects
// - row select low with row address
// - column select low with column address
// - write enable low write, high read
// - other commands use sdram truth table
// - high mask blocks the data word
// - mask only with column select, not reads
// - separate address bit ten output
// - clock enable enters, leaves self-refresh/suspend
// - bus release: self-refresh, then float outputs
module sdfb_ctrl (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // dma request pins and channel setup
    input  wire logic [3:0]         ext_dma_request,
    input  wire logic [3:0]         chan_initialised,
    input  wire logic [3:0]         chan_flyby_write,
    // core access request, taken when ready
    input  wire sdfb_pkg::sdfb_req_t core_req,
    output logic                    core_ready,
    output logic [3:0]              dma_ack,
    // bus ownership and power control
    input  wire logic               bus_owner,
    input  wire logic               host_bus_request,
    input  wire logic               suspend_req,
    output logic                    host_bus_grant,
    // sdram pins
    output sdfb_pkg::sdfb_pins_t    sdram_pins,
    output logic                    sdram_pins_oe,
    // fly-by io pins
    output sdfb_pkg::sdfb_io_t      flyby_io,
    output logic                    flyby_io_oe
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACT, ST_WAIT, ST_COL, ST_PRE, ST_SREF, ST_RELEASED, ST_SUSP
    } sdfb_state_t;

    // ==========================================================
    // synchronisers
    logic [3:0] dreq_meta_q, dreq_sync_q;
    logic       hbr_meta_q,  hbr_sync_q;

    // two flop sync
    // requests are levels; a pulse under one clock may be missed
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dreq_meta_q <= 4'h0;
            dreq_sync_q <= 4'h0;
            hbr_meta_q  <= 1'b0;
            hbr_sync_q  <= 1'b0;
        end else begin
            dreq_meta_q <= ext_dma_request;
            dreq_sync_q <= dreq_meta_q;
            hbr_meta_q  <= host_bus_request;
            hbr_sync_q  <= hbr_meta_q;
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [3:0] bank_decode(input logic [31:0] a);
        bank_decode = 4'h1 << a[`SDFB_BANK_SEL_HI:`SDFB_BANK_SEL_LO];
    endfunction : bank_decode

    function automatic logic in_sdram_space(input logic [31:0] a);
        in_sdram_space = (a[`SDFB_ADDR_TOP_HI:`SDFB_ADDR_TOP_LO] == `SDFB_SDRAM_SPACE)
                      && (a[`SDFB_RSVD_HI:`SDFB_RSVD_LO] != `SDFB_RSVD_CODE);
    endfunction : in_sdram_space

    function automatic logic [1:0] pick_chan(input logic [3:0] v);
        pick_chan = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
    endfunction : pick_chan

    // ==========================================================
    // sequencer
    sdfb_state_t         state_q, state_d;
    sdfb_pkg::sdfb_req_t cur_q, cur_d;
    logic [1:0]          wait_q, wait_d;
    logic [3:0]          ack_q, ack_d;
    logic                rdy_q, rdy_d;
    logic                grant_q, grant_d;
    sdfb_pkg::sdfb_pins_t pins_q, pins_d;
    sdfb_pkg::sdfb_io_t  io_q, io_d;
    logic                pins_oe_q, pins_oe_d;
    logic                io_oe_q, io_oe_d;
    logic [3:0]          dma_live;
    logic [1:0]          ch;

    assign dma_live = dreq_sync_q & chan_initialised;
    assign ch       = pick_chan(dma_live);

    always_comb begin
        state_d   = state_q;
        cur_d     = cur_q;
        wait_d    = wait_q;
        ack_d     = 4'h0;
        rdy_d     = 1'b0;
        grant_d   = grant_q;
        pins_d    = pins_q;
        io_d      = '0;
        io_oe_d   = bus_owner;
        pins_oe_d = bus_owner;
        {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_NOP;
        pins_d.bank_sel = `SDFB_BANK_RST;
        pins_d.mask     = 1'b0;
        case (state_q)
            ST_IDLE: begin
                pins_d.cke = 1'b1;
                if (hbr_sync_q) begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_REFRESH;
                    // one line only, so the entry still decodes as a single bank
                    pins_d.bank_sel = bank_decode(cur_q.addr);
                    pins_d.cke      = 1'b0;
                    state_d         = ST_SREF;
                end else if (suspend_req) begin
                    pins_d.cke = 1'b0;
                    state_d    = ST_SUSP;
                end else if (bus_owner && |dma_live) begin
                    // start transfer on channel
                    // lowest channel wins; a busy low channel can starve the rest
                    ack_d[ch]   = 1'b1;
                    cur_d.valid = 1'b1;
                    cur_d.op    = chan_flyby_write[ch] ? sdfb_pkg::SDFB_OP_WRITE
                                                       : sdfb_pkg::SDFB_OP_READ;
                    cur_d.addr  = core_req.addr;
                    cur_d.mask  = 1'b0;
                    cur_d.flyby = 1'b1;
                    state_d     = ST_ACT;
                end else if (bus_owner && core_req.valid && in_sdram_space(core_req.addr)) begin
                    // ready leads the activate by one cycle
                    rdy_d   = 1'b1;
                    cur_d   = core_req;
                    state_d = ST_ACT;
                end
            end
            ST_ACT: begin
                pins_d.bank_sel = bank_decode(cur_q.addr);
                pins_d.a10      = cur_q.addr[`SDFB_A10_BIT];
                if (cur_q.op == sdfb_pkg::SDFB_OP_REFRESH) begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_REFRESH;
                    state_d = ST_IDLE;
                end else if (cur_q.op == sdfb_pkg::SDFB_OP_MODE) begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_MODE;
                    pins_d.addr = cur_q.addr[`SDFB_ROW_HI:`SDFB_ROW_LO];
                    state_d     = ST_IDLE;
                end else begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_ACT;
                    pins_d.addr = cur_q.addr[`SDFB_ROW_HI:`SDFB_ROW_LO];
                    wait_d      = 2'(`SDFB_TRCD_CYC - 1);
                    state_d     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // one nop between activate and column covers trcd
                if (wait_q <= 2'h1) begin
                    state_d = ST_COL;
                end else begin
                    wait_d = wait_q - 2'h1;
                end
            end
            ST_COL: begin
                pins_d.bank_sel = bank_decode(cur_q.addr);
                pins_d.a10      = 1'b0;
                pins_d.addr     = {4'h0, cur_q.addr[`SDFB_COL_HI:`SDFB_COL_LO]};
                if (cur_q.op == sdfb_pkg::SDFB_OP_WRITE) begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_WRITE;
                    pins_d.mask = cur_q.mask;
                end else begin
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_READ;
                end
                // single word per access, so strobes stand one cycle
                // io enable only on fly-by
                if (cur_q.flyby) begin
                    io_d.wr_strobe = (cur_q.op == sdfb_pkg::SDFB_OP_READ);
                    io_d.rd_strobe = (cur_q.op == sdfb_pkg::SDFB_OP_WRITE);
                    io_d.out_en    = (cur_q.op == sdfb_pkg::SDFB_OP_WRITE);
                end
                wait_d  = 2'(`SDFB_TRP_CYC);
                state_d = ST_PRE;
            end
            ST_PRE: begin
                if (wait_q == 2'(`SDFB_TRP_CYC)) begin
                    // precharge all banks
                    // a10 high closes every open row, not just this bank
                    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdfb_pkg::SDFB_CMD_PRE;
                    pins_d.bank_sel = bank_decode(cur_q.addr);
                    pins_d.a10      = 1'b1;
                end
                if (wait_q <= 2'h1) begin
                    cur_d.valid = 1'b0;
                    state_d     = ST_IDLE;
                end else begin
                    wait_d = wait_q - 2'h1;
                end
            end
            ST_SREF: begin
                // float pins, assert grant
                // pins float a cycle after entry so the command still lands
                pins_d.cke = 1'b0;
                grant_d    = 1'b1;
                pins_oe_d  = 1'b0;
                io_oe_d    = 1'b0;
                state_d    = ST_RELEASED;
            end
            ST_RELEASED: begin
                pins_d.cke = 1'b0;
                pins_oe_d  = 1'b0;
                io_oe_d    = 1'b0;
                if (!hbr_sync_q) begin
                    // exit self-refresh
                    // no exit delay count: the host must hold off long enough
                    grant_d    = 1'b0;
                    pins_d.cke = 1'b1;
                    pins_oe_d  = bus_owner;
                    io_oe_d    = bus_owner;
                    state_d    = ST_IDLE;
                end
            end
            ST_SUSP: begin
                pins_d.cke = 1'b0;
                if (!suspend_req) begin
                    pins_d.cke = 1'b1;
                    state_d    = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // non-owner leaves pins undriven
        // a sequence runs on when ownership goes; only drivers float
        if (!bus_owner) begin
            pins_oe_d = 1'b0;
            io_oe_d   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q   <= ST_IDLE;
            cur_q     <= '0;
            wait_q    <= 2'h0;
            ack_q     <= 4'h0;
            rdy_q     <= 1'b0;
            grant_q   <= 1'b0;
            pins_q    <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank_sel: `SDFB_BANK_RST,
                           a10: 1'b0, addr: 14'h0, mask: 1'b0, cke: 1'b1};
            io_q      <= '0;
            pins_oe_q <= 1'b0;
            io_oe_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            cur_q     <= cur_d;
            wait_q    <= wait_d;
            ack_q     <= ack_d;
            rdy_q     <= rdy_d;
            grant_q   <= grant_d;
            pins_q    <= pins_d;
            io_q      <= io_d;
            pins_oe_q <= pins_oe_d;
            io_oe_q   <= io_oe_d;
        end
    end

    assign sdram_pins     = pins_q;
    assign sdram_pins_oe  = pins_oe_q;
    assign flyby_io       = io_q;
    assign flyby_io_oe    = io_oe_q;
    assign dma_ack        = ack_q;
    assign core_ready     = rdy_q;
    assign host_bus_grant = grant_q;

endmodule : sdfb_ctrl

/* hdl/sdfb_pkg.sv */
package sdfb_pkg;

    // ras_n, cas_n, we_n
    typedef enum logic [2:0] {
        SDFB_CMD_NOP     = 3'h7,
        SDFB_CMD_ACT     = 3'h3,
        SDFB_CMD_READ    = 3'h5,
        SDFB_CMD_WRITE   = 3'h4,
        SDFB_CMD_PRE     = 3'h2,
        SDFB_CMD_REFRESH = 3'h1,
        SDFB_CMD_MODE    = 3'h0
    } sdfb_cmd_t;

    typedef enum logic [1:0] {
        SDFB_OP_READ,
        SDFB_OP_WRITE,
        SDFB_OP_REFRESH,
        SDFB_OP_MODE
    } sdfb_op_t;

    typedef struct packed {
        logic        valid;
        sdfb_op_t    op;
        logic [31:0] addr;
        logic        mask;
        logic        flyby;
    } sdfb_req_t;

    typedef struct packed {
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [3:0]  bank_sel;
        logic        a10;
        logic [13:0] addr;
        logic        mask;
        logic        cke;
    } sdfb_pins_t;

    typedef struct packed {
        logic wr_strobe;
        logic rd_strobe;
        logic out_en;
    } sdfb_io_t;

endpackage : sdfb_pkg

/* verification/sdfb_ctrl_asserts.sv */
`timescale 1ns/100ps
// ==========================================
// sdram and fly-by pin checker
module sdfb_ctrl_asserts (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rstn,
    // causes
    input wire logic [3:0]           ext_dma_request,
    input wire logic [3:0]           chan_initialised,
    input wire sdfb_pkg::sdfb_req_t  core_req,
    input wire logic                 bus_owner,
    // effects
    input wire logic                 core_ready,
    input wire logic [3:0]           dma_ack,
    input wire logic                 host_bus_grant,
    input wire sdfb_pkg::sdfb_pins_t sdram_pins,
    input wire logic                 sdram_pins_oe,
    input wire sdfb_pkg::sdfb_io_t   flyby_io,
    input wire logic                 flyby_io_oe
);
    localparam logic [2:0] C_NOP = sdfb_pkg::SDFB_CMD_NOP;
    localparam logic [2:0] C_ACT = sdfb_pkg::SDFB_CMD_ACT;
    localparam logic [2:0] C_RD  = sdfb_pkg::SDFB_CMD_READ;
    localparam logic [2:0] C_WR  = sdfb_pkg::SDFB_CMD_WRITE;
    localparam logic [2:0] C_PRE = sdfb_pkg::SDFB_CMD_PRE;
    localparam logic [2:0] C_REF = sdfb_pkg::SDFB_CMD_REFRESH;
    logic [2:0] cmd;
    assign cmd = {sdram_pins.ras_n, sdram_pins.cas_n, sdram_pins.we_n};
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_act;
        cmd == C_ACT;
    endsequence
    sequence s_col;
        cmd == C_RD || cmd == C_WR;
    endsequence
    sequence s_pre;
        cmd == C_PRE && sdram_pins.a10;
    endsequence
    a_row_then_col: assert property (s_act |=> cmd == C_NOP ##1 s_col ##1 s_pre)
        else $error("column step out of order");
    a_bank_onehot: assert property (cmd != C_NOP
        |-> $onehot(sdram_pins.bank_sel)) else $error("bank select not one-hot");
    a_bank_decode: assert property (core_ready
        && ($past(core_req.op) == sdfb_pkg::SDFB_OP_READ
            || $past(core_req.op) == sdfb_pkg::SDFB_OP_WRITE)
        |=> cmd == C_ACT && sdram_pins.bank_sel == 4'h1 << $past(core_req.addr[29:28], 2))
        else $error("bank wrong");
    a_owner_only: assert property (!bus_owner |=> !sdram_pins_oe)
        else $error("pins driven without bus");
    a_mask_on_write: assert property (sdram_pins.mask |-> cmd == C_WR)
        else $error("mask outside write column");
    a_ack_synced: assert property ((dma_ack & ~$past(ext_dma_request, 3)) == 4'h0)
        else $error("request served too early");
    a_ack_init: assert property ((dma_ack & ~$past(chan_initialised)) == 4'h0)
        else $error("unset channel served");
    a_ack_start: assert property (dma_ack != 4'h0
        |-> $onehot(dma_ack) ##1 (dma_ack == 4'h0 && cmd == C_ACT)) else $error("ack wrong");
    a_wr_strobe: assert property (flyby_io.wr_strobe |-> cmd == C_RD)
        else $error("write strobe outside read");
    a_rd_strobe: assert property (flyby_io.rd_strobe |-> cmd == C_WR && flyby_io.out_en)
        else $error("read strobe outside write");
    a_host_float: assert property (host_bus_grant
        |-> !sdram_pins_oe && !flyby_io_oe && !sdram_pins.cke) else $error("pins not released");
    a_self_refresh: assert property (cmd == C_REF && !sdram_pins.cke |=> host_bus_grant)
        else $error("grant missing after self-refresh");
endmodule : sdfb_ctrl_asserts

/* verification/sdfb_io_dev.sv */
`timescale 1ns/100ps
// ==========================================
// external fly-by io device
module sdfb_io_dev (
    // clock
    input  wire logic               ref_clk,
    // bench control and design pins
    input  wire logic [3:0]         raise,
    input  wire logic [3:0]         dma_ack,
    input  wire sdfb_pkg::sdfb_io_t flyby_io,
    // device side
    output logic [3:0]              ext_dma_request,
    output int                      n_captured,
    output int                      n_driven
);
    initial begin
        ext_dma_request = 4'h0;
        n_captured = 0;
        n_driven = 0;
    end
    always @(posedge ref_clk) begin
        // hold request until served
        // skewed off the edge: the pin is asynchronous
        ext_dma_request <= #7 (ext_dma_request | raise) & ~dma_ack;
        if (flyby_io.wr_strobe === 1'b1) n_captured <= n_captured + 1;
        if (flyby_io.rd_strobe === 1'b1 && flyby_io.out_en === 1'b1) n_driven <= n_driven + 1;
    end
endmodule : sdfb_io_dev

/* verification/test_sdram_and_flyby_dma_signalling.sv */
`timescale 1ns/100ps
// ==========================================
// bench top
module test_sdram_and_flyby_dma_signalling;
    localparam logic [2:0] C_NOP = sdfb_pkg::SDFB_CMD_NOP;
    localparam logic [2:0] C_ACT = sdfb_pkg::SDFB_CMD_ACT;
    localparam logic [2:0] C_RD  = sdfb_pkg::SDFB_CMD_READ;
    localparam logic [2:0] C_WR  = sdfb_pkg::SDFB_CMD_WRITE;
    localparam logic [2:0] C_PRE = sdfb_pkg::SDFB_CMD_PRE;
    logic                 ref_clk, rstn, bus_owner, host_bus_request, suspend_req;
    logic                 core_ready, host_bus_grant, sdram_pins_oe, flyby_io_oe;
    logic [3:0]           chan_initialised, chan_flyby_write, raise, ext_dma_request, dma_ack;
    sdfb_pkg::sdfb_req_t  core_req;
    sdfb_pkg::sdfb_pins_t sdram_pins;
    sdfb_pkg::sdfb_io_t   flyby_io;
    int                   num_errors, n_compared, n_captured, n_driven;
    logic [2:0]           cmd;
    assign cmd = {sdram_pins.ras_n, sdram_pins.cas_n, sdram_pins.we_n};
    sdfb_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .ext_dma_request(ext_dma_request),
        .chan_initialised(chan_initialised), .chan_flyby_write(chan_flyby_write),
        .core_req(core_req), .core_ready(core_ready), .dma_ack(dma_ack), .bus_owner(bus_owner),
        .host_bus_request(host_bus_request), .suspend_req(suspend_req),
        .host_bus_grant(host_bus_grant), .sdram_pins(sdram_pins),
        .sdram_pins_oe(sdram_pins_oe), .flyby_io(flyby_io), .flyby_io_oe(flyby_io_oe));
    sdfb_io_dev u_dev (.ref_clk(ref_clk), .raise(raise), .dma_ack(dma_ack), .flyby_io(flyby_io),
        .ext_dma_request(ext_dma_request), .n_captured(n_captured), .n_driven(n_driven));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // settle 1 ns past the edge so registered outputs have landed
    task cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cycles
    task wait_for(input int sel);
        for (int i = 0; i < 24; i++) begin
            cycles(1);
            if ((sel == 0 && core_ready === 1'b1) || (sel == 1 && dma_ack !== 4'h0)
                || (sel == 2 && host_bus_grant === 1'b1) || (sel == 3 && host_bus_grant === 1'b0))
                return;
        end
        num_errors++;
        $display("ERROR %0t ns: wait timed out", $time);
        end_of_test();
    endtask : wait_for
    task t_access(input sdfb_pkg::sdfb_op_t op, input logic [31:0] a, input logic m);
        @(posedge ref_clk);
        core_req <= '{1'b1, op, a, m, 1'b0};
        wait_for(0);
        @(posedge ref_clk);
        core_req.valid <= 1'b0;
        // the command word stands one cycle after ready
        #1;
        if (op == sdfb_pkg::SDFB_OP_REFRESH) check(cmd, sdfb_pkg::SDFB_CMD_REFRESH);
        else if (op == sdfb_pkg::SDFB_OP_MODE) check(cmd, sdfb_pkg::SDFB_CMD_MODE);
        else begin
            check(cmd, C_ACT);
            check(sdram_pins.bank_sel, 4'h1 << a[29:28]);
            check(sdram_pins.addr, a[25:12]);
        end
        if (op == sdfb_pkg::SDFB_OP_READ || op == sdfb_pkg::SDFB_OP_WRITE) begin
            cycles(2);
            check(cmd, (op == sdfb_pkg::SDFB_OP_WRITE) ? C_WR : C_RD);
            check(sdram_pins.mask, m && op == sdfb_pkg::SDFB_OP_WRITE);
            check(flyby_io, 3'h0);
            cycles(1);
            check({cmd, sdram_pins.a10}, {C_PRE, 1'b1});
        end
        cycles(3);
    endtask : t_access
    task t_idle(input logic [31:0] a, input logic own);
        @(posedge ref_clk);
        core_req <= '{1'b1, sdfb_pkg::SDFB_OP_READ, a, 1'b0, 1'b0};
        bus_owner <= own;
        repeat (10) begin
            cycles(1);
            check({core_ready, cmd}, {1'b0, C_NOP});
        end
        check(sdram_pins_oe, own);
        @(posedge ref_clk);
        core_req.valid <= 1'b0;
        bus_owner <= 1'b1;
    endtask : t_idle
    task t_dma(input int ch);
        @(posedge ref_clk);
        raise[ch] <= 1'b1;
        chan_flyby_write[ch] <= ch[0];
        core_req.addr <= {2'h1, ch[1:0], 28'h0};
        @(posedge ref_clk);
        raise <= 4'h0;
        repeat (12) begin
            cycles(1);
            check(dma_ack, 4'h0);
        end
        @(posedge ref_clk);
        chan_initialised[ch] <= 1'b1;
        wait_for(1);
        check(dma_ack, 4'h1 << ch);
        cycles(1);
        check(cmd, C_ACT);
        check(sdram_pins.bank_sel, 4'h1 << ch);
        cycles(2);
        check({flyby_io.wr_strobe, flyby_io.rd_strobe}, {!ch[0], ch[0]});
        if (ch[0]) check(flyby_io.out_en, 1'b1);
        check(sdram_pins.mask, 1'b0);
        cycles(4);
    endtask : t_dma
    task t_power;
        @(posedge ref_clk);
        host_bus_request <= 1'b1;
        wait_for(2);
        check({sdram_pins_oe, flyby_io_oe, sdram_pins.cke}, 3'h0);
        @(posedge ref_clk);
        host_bus_request <= 1'b0;
        wait_for(3);
        cycles(1);
        check(sdram_pins.cke, 1'b1);
        @(posedge ref_clk);
        suspend_req <= 1'b1;
        cycles(3);
        check(sdram_pins.cke, 1'b0);
        @(posedge ref_clk);
        suspend_req <= 1'b0;
        cycles(3);
        check(sdram_pins.cke, 1'b1);
    endtask : t_power
    initial begin
        {rstn, host_bus_request, suspend_req} = 3'h0;
        bus_owner = 1'b1;
        {chan_initialised, chan_flyby_write, raise} = 12'h0;
        core_req = '0;
        num_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        check({cmd, sdram_pins.bank_sel, sdram_pins.cke, dma_ack}, {C_NOP, 4'h0, 1'b1, 4'h0});
        check({sdram_pins_oe, host_bus_grant, core_ready}, 3'h0);
        cycles(2);
        check(sdram_pins_oe, 1'b1);
        for (int b = 0; b < 4; b++) begin
            t_access(sdfb_pkg::SDFB_OP_READ, {2'h1, b[1:0], 2'h1, 14'h2a5, 12'h0}, b[0]);
            t_access(sdfb_pkg::SDFB_OP_WRITE, {2'h1, b[1:0], 2'h0, 14'h15a, 12'h0}, b[0]);
        end
        t_access(sdfb_pkg::SDFB_OP_REFRESH, 32'h4000_0000, 1'b0);
        t_access(sdfb_pkg::SDFB_OP_MODE, 32'h4000_0000, 1'b0);
        t_idle(32'h4c00_0000, 1'b1);
        t_idle(32'h8000_0000, 1'b1);
        t_idle(32'h4000_0000, 1'b0);
        for (int c = 0; c < 4; c++) t_dma(c);
        check(n_captured, 2);
        check(n_driven, 2);
        t_power();
        end_of_test();
    end
endmodule : test_sdram_and_flyby_dma_signalling
bind sdfb_ctrl sdfb_ctrl_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
    .ext_dma_request(ext_dma_request), .chan_initialised(chan_initialised),
    .core_req(core_req), .bus_owner(bus_owner), .core_ready(core_ready), .dma_ack(dma_ack),
    .host_bus_grant(host_bus_grant), .sdram_pins(sdram_pins), .sdram_pins_oe(sdram_pins_oe),
    .flyby_io(flyby_io), .flyby_io_oe(flyby_io_oe));
